// ### i2c_slave_pkg.sv
// package: constants and state types for the i2c slave sequencer
package i2c_slave_pkg;
  localparam int unsigned SYS_CLK_HZ = 20000000;
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  localparam logic [3:0] ACK_BIT_INDEX = 4'h9;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_IGNORE,
    ST_RX,
    ST_TX
  } seq_state_t;
endpackage : i2c_slave_pkg

// ### i2c_pin_sync.sv
// two-flop synchroniser with match filter for a bus pin
`timescale 1ns/100ps
module i2c_pin_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic pin_in,
  output logic pin_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;
  sync_t q;
  sync_t d;

  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.lvl;
endmodule : i2c_pin_sync

// ### i2c_slave_seq.sv
// i2c slave receive / transmit sequencer with flags and scl hold
`timescale 1ns/100ps
module i2c_slave_seq (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [6:0] own_addr,
  input wire logic handshake_hold_en,
  input wire logic irq_enable,
  input wire logic stop_irq_mask,
  input wire logic ext_addr_match_flag,
  input wire logic ack_data_wr,
  input wire logic ack_data_wval,
  input wire logic tx_select_wr,
  input wire logic tx_select_wval,
  input wire logic irq_flag_clr,
  input wire logic xfer_request_clr,
  input wire logic stop_flag_clr,
  input wire logic data_reg_wr,
  input wire logic [7:0] data_reg_wdata,
  input wire logic data_reg_rd,
  output logic [7:0] data_reg_rdata,
  output logic ack_data_bit,
  output logic tx_select,
  output logic irq_flag,
  output logic xfer_request_flag,
  output logic rx_buf_full,
  output logic tx_buf_empty,
  output logic bus_busy_flag,
  output logic stop_flag,
  output logic error_stop_flag,
  output logic irq_out
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    i2c_slave_pkg::seq_state_t st;
    logic scl_p;
    logic sda_p;
    logic [3:0] bit_cnt;
    logic [7:0] shift_reg;
    logic [7:0] rx_buffer;
    logic [7:0] data_reg;
    logic tx_loaded;
    logic rx_pending;
    logic sda_low;
    logic scl_hold;
    logic ack_data_bit;
    logic tx_select;
    logic irq_flag;
    logic xfer_request_flag;
    logic rx_buf_full;
    logic tx_buf_empty;
    logic bus_busy_flag;
    logic stop_flag;
    logic error_stop_flag;
    logic irq_out;
  } seq_t;
  seq_t q;
  seq_t d;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  i2c_pin_sync u_scl_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(scl_in),
    .pin_out(scl_s)
  );
  i2c_pin_sync u_sda_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(sda_in),
    .pin_out(sda_s)
  );

  assign scl_rise = scl_s && !q.scl_p;
  assign scl_fall = !scl_s && q.scl_p;
  assign start_det = scl_s && q.scl_p && q.sda_p && !sda_s;
  assign stop_det = scl_s && q.scl_p && !q.sda_p && sda_s;

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_comb begin
    d = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    // software clears first so hardware sets win
    if (irq_flag_clr) begin
      d.irq_flag = 1'b0;
    end
    if (xfer_request_clr) begin
      d.xfer_request_flag = 1'b0;
    end
    if (stop_flag_clr) begin
      d.stop_flag = 1'b0;
      d.error_stop_flag = 1'b0;
    end
    if (ack_data_wr) begin
      d.ack_data_bit = ack_data_wval;
    end
    if (tx_select_wr) begin
      d.tx_select = tx_select_wval;
    end
    // data register read
    if (data_reg_rd) begin
      d.rx_buf_full = 1'b0;
      if (!q.tx_select) begin
        d.sda_low = 1'b0;
      end
      if (q.scl_hold && (q.st == i2c_slave_pkg::ST_RX || !q.tx_select)) begin
        d.scl_hold = 1'b0;
      end
      if (q.rx_pending) begin
        d.rx_buffer = q.shift_reg;
        d.rx_pending = 1'b0;
        d.rx_buf_full = 1'b1;
        d.irq_flag = 1'b1;
      end
    end
    // data register write in transmit
    if (data_reg_wr && q.tx_select) begin
      d.data_reg = data_reg_wdata;
      d.tx_buf_empty = 1'b0;
      d.tx_loaded = 1'b1;
    end
    // load shifter while scl is stretched in transmit
    if (q.tx_loaded && q.st == i2c_slave_pkg::ST_TX && q.scl_hold) begin
      d.shift_reg = q.data_reg;
      d.tx_loaded = 1'b0;
      d.tx_buf_empty = 1'b1;
      d.irq_flag = 1'b1;
      d.scl_hold = 1'b0;
      d.sda_low = !q.data_reg[7];
      d.bit_cnt = i2c_slave_pkg::BIT_COUNT_RESET;
    end

    if (start_det) begin
      d.bus_busy_flag = 1'b1;
      d.st = i2c_slave_pkg::ST_ADDR;
      d.bit_cnt = i2c_slave_pkg::BIT_COUNT_RESET;
      d.sda_low = 1'b0;
      d.scl_hold = 1'b0;
    end else if (stop_det) begin
      d.bus_busy_flag = 1'b0;
      if (q.bit_cnt <= 4'h1 || q.st == i2c_slave_pkg::ST_IDLE ||
          q.st == i2c_slave_pkg::ST_IGNORE) begin
        d.stop_flag = 1'b1;
      end else begin
        d.error_stop_flag = 1'b1;
      end
      if (!stop_irq_mask) begin
        d.irq_flag = 1'b1;
      end
      d.st = i2c_slave_pkg::ST_IDLE;
      d.sda_low = 1'b0;
      d.scl_hold = 1'b0;
      d.bit_cnt = i2c_slave_pkg::BIT_COUNT_RESET;
    end else if (q.st != i2c_slave_pkg::ST_IDLE &&
                 q.st != i2c_slave_pkg::ST_IGNORE) begin
      if (scl_rise) begin
        if (q.bit_cnt < i2c_slave_pkg::DATA_BITS) begin
          d.bit_cnt = q.bit_cnt + 4'h1;
          if (q.st != i2c_slave_pkg::ST_TX) begin
            d.shift_reg = {q.shift_reg[6:0], sda_s};
          end
        end else begin
          // rising edge of the 9th clock
          d.bit_cnt = i2c_slave_pkg::ACK_BIT_INDEX;
          case (q.st)
            i2c_slave_pkg::ST_ADDR: begin
              d.irq_flag = 1'b1;
              d.tx_select = q.shift_reg[0];
              if (q.shift_reg[0]) begin
                d.st = i2c_slave_pkg::ST_TX;
                d.tx_buf_empty = 1'b1;
              end else begin
                d.st = i2c_slave_pkg::ST_RX;
              end
            end
            i2c_slave_pkg::ST_RX: begin
              d.irq_flag = 1'b1;
              if (ext_addr_match_flag) begin
                d.xfer_request_flag = 1'b1;
              end
              if (!q.rx_buf_full || data_reg_rd) begin
                d.rx_buffer = q.shift_reg;
                d.rx_buf_full = 1'b1;
              end else begin
                d.rx_pending = 1'b1;
              end
            end
            i2c_slave_pkg::ST_TX: begin
              d.ack_data_bit = sda_s;
              d.irq_flag = 1'b1;
            end
            default: begin
              d.st = q.st;
            end
          endcase
        end
      end else if (scl_fall) begin
        case (q.bit_cnt)
          4'h7: begin
            if (q.st == i2c_slave_pkg::ST_TX) begin
              // last data bit of the byte
              d.sda_low = !q.shift_reg[0];
            end
          end
          4'h8: begin
            if (q.st == i2c_slave_pkg::ST_ADDR) begin
              if (q.shift_reg[7:1] == own_addr) begin
                d.sda_low = 1'b1;
              end else begin
                d.st = i2c_slave_pkg::ST_IGNORE;
              end
            end else if (q.st == i2c_slave_pkg::ST_RX) begin
              d.sda_low = !q.ack_data_bit;
            end else begin
              d.sda_low = 1'b0; // release for master ack
            end
          end
          i2c_slave_pkg::ACK_BIT_INDEX: begin
            d.bit_cnt = i2c_slave_pkg::BIT_COUNT_RESET;
            d.sda_low = 1'b0;
            if (q.st == i2c_slave_pkg::ST_TX) begin
              if (q.tx_loaded) begin
                d.shift_reg = q.data_reg;
                d.tx_loaded = 1'b0;
                d.tx_buf_empty = 1'b1;
                d.irq_flag = 1'b1;
                d.sda_low = !q.data_reg[7];
              end else begin
                d.scl_hold = 1'b1;
              end
            end else if (q.st == i2c_slave_pkg::ST_RX &&
                         handshake_hold_en && !data_reg_rd) begin
              d.scl_hold = 1'b1;
            end
          end
          default: begin
            if (q.st == i2c_slave_pkg::ST_TX) begin
              d.sda_low = !q.shift_reg[3'(4'h7 - q.bit_cnt)];
            end
          end
        endcase
      end
    end
    d.irq_out = d.irq_flag && irq_enable;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= i2c_slave_pkg::ST_IDLE;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign scl_out = 1'b0;
  assign scl_oe_n = !q.scl_hold;
  assign sda_out = 1'b0;
  assign sda_oe_n = !q.sda_low;
  assign data_reg_rdata = q.rx_buffer;
  assign ack_data_bit = q.ack_data_bit;
  assign tx_select = q.tx_select;
  assign irq_flag = q.irq_flag;
  assign xfer_request_flag = q.xfer_request_flag;
  assign rx_buf_full = q.rx_buf_full;
  assign tx_buf_empty = q.tx_buf_empty;
  assign bus_busy_flag = q.bus_busy_flag;
  assign stop_flag = q.stop_flag;
  assign error_stop_flag = q.error_stop_flag;
  assign irq_out = q.irq_out;
endmodule : i2c_slave_seq

// ### i2c_slave_assertions.sv
// assertion checker bound to the i2c slave sequencer
`timescale 1ns/100ps
module i2c_slave_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe_n,
  input wire logic handshake_hold_en,
  input wire logic irq_flag_clr,
  input wire logic data_reg_rd,
  input wire logic tx_select,
  input wire logic irq_flag,
  input wire logic rx_buf_full,
  input wire logic tx_buf_empty,
  input wire logic bus_busy_flag,
  input wire logic stop_flag,
  input wire logic error_stop_flag
);
  // **********
  // port checks
  // **********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  busy_on_start_a:
    assert property ($fell(sda_in) && scl_in && !bus_busy_flag |->
      ##[1:8] bus_busy_flag) else $error("busy not set");
  stop_clears_a:
    assert property ($rose(sda_in) && scl_in && bus_busy_flag |->
      ##[1:8] (!bus_busy_flag && (stop_flag || error_stop_flag)))
      else $error("stop not seen");
  irq_holds_a:
    assert property (irq_flag && !irq_flag_clr |=> irq_flag)
      else $error("irq dropped");
  rx_hold_a:
    assert property ($rose(rx_buf_full) && handshake_hold_en |->
      ##[1:20] !scl_oe_n) else $error("scl not held");
  read_release_a:
    assert property (data_reg_rd && rx_buf_full && handshake_hold_en &&
      !tx_select |-> ##[1:6] (!rx_buf_full && scl_oe_n))
      else $error("read did not release");
  full_irq_a:
    assert property ($rose(rx_buf_full) |-> irq_flag)
      else $error("full without irq");
  read_addr_a:
    assert property ($rose(tx_select) |-> tx_buf_empty && irq_flag)
      else $error("read address flags");
  tx_stretch_a:
    assert property ($rose(tx_select) |-> ##[1:20] !scl_oe_n)
      else $error("tx scl not held");
endmodule : i2c_slave_assertions

bind i2c_slave_seq i2c_slave_assertions chk (.sys_clk, .arst_n, .scl_in,
  .sda_in, .scl_oe_n, .handshake_hold_en, .irq_flag_clr, .data_reg_rd,
  .tx_select, .irq_flag, .rx_buf_full, .tx_buf_empty, .bus_busy_flag,
  .stop_flag, .error_stop_flag);

// ### i2c_master_model.sv
// behavioural i2c bus master for the slave pins
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull,
  output logic tmo
);
  // **********
  // bus phases
  // **********
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    tmo = 1'b0;
  end
  task automatic rise;
    int n;
    n = 0;
    scl_pull = 1'b0;
    while (scl_line !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    if (n >= 4000) tmo = 1'b1;
    #90;
  endtask : rise
  task automatic clk(input logic b, output logic s);
    #107 sda_pull = !b;
    #193;
    rise();
    s = sda_line;
    #10 scl_pull = 1'b1;
  endtask : clk
  task automatic start;
    #107 sda_pull = 1'b1;
    #200 scl_pull = 1'b1;
  endtask : start
  task automatic stop;
    #100 sda_pull = 1'b1;
    #200;
    rise();
    #100 sda_pull = 1'b0;
  endtask : stop
  task automatic xfer(input logic [7:0] wb, input logic ab,
    output logic [7:0] rb, output logic ack);
    for (int i = 7; i >= 0; i--) clk(wb[i], rb[i]);
    clk(ab, ack);
  endtask : xfer
endmodule : i2c_master_model

// ### tb_top.sv
// self-checking bench for the i2c slave sequencer
`timescale 1ns/100ps
module tb_top;
  logic sys_clk, arst_n, handshake_hold_en, irq_enable, stop_irq_mask;
  logic ext_addr_match_flag, ack_data_wval, tx_select_wval, ack, m_scl;
  logic [6:0] own_addr, ctl;
  logic [7:0] data_reg_wdata, data_reg_rdata, rb;
  logic ack_data_bit, tx_select, irq_flag, xfer_request_flag, rx_buf_full;
  logic tx_buf_empty, bus_busy_flag, stop_flag, error_stop_flag, irq_out;
  logic scl_oe_n, sda_oe_n, m_sda, tmo, scl_o, sda_o;
  logic [31:0] seed;
  int err_count, samples_checked;
  logic [7:0] exp_q[$];
  wire scl_in = !(m_scl || !scl_oe_n);
  wire sda_in = !(m_sda || !sda_oe_n);
  // **********
  // harness and tasks
  // **********
  i2c_slave_seq dut (.sys_clk, .arst_n, .scl_in, .sda_in, .scl_out(scl_o),
    .scl_oe_n, .sda_out(sda_o), .sda_oe_n, .own_addr, .handshake_hold_en,
    .irq_enable, .stop_irq_mask, .ext_addr_match_flag,
    .ack_data_wr(ctl[0]), .ack_data_wval, .tx_select_wr(ctl[1]),
    .tx_select_wval, .irq_flag_clr(ctl[2]), .xfer_request_clr(ctl[3]),
    .stop_flag_clr(ctl[4]), .data_reg_wr(ctl[5]), .data_reg_wdata,
    .data_reg_rd(ctl[6]), .data_reg_rdata, .ack_data_bit, .tx_select,
    .irq_flag, .xfer_request_flag, .rx_buf_full, .tx_buf_empty,
    .bus_busy_flag, .stop_flag, .error_stop_flag, .irq_out);
  i2c_master_model m (.scl_line(scl_in), .sda_line(sda_in),
    .scl_pull(m_scl), .sda_pull(m_sda), .tmo(tmo));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = !sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic pulse(input int i);
    @(negedge sys_clk) ctl[i] = 1'b1;
    @(negedge sys_clk) ctl[i] = 1'b0;
  endtask : pulse
  task automatic wr(input logic [7:0] b, input logic ab);
    m.xfer(b, ab, rb, ack);
    repeat (8) @(negedge sys_clk);
  endtask : wr
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  always @(posedge tmo) begin
    err_count++;
    results();
  end
  initial begin
    #1000000;
    err_count++;
    results();
  end
  initial begin
    seed = 32'h7745;
    own_addr = seed[6:0];
    {arst_n, handshake_hold_en, ext_addr_match_flag, ack_data_wval} = '0;
    {tx_select_wval, ctl, data_reg_wdata} = '0;
    irq_enable = 1'b1;
    stop_irq_mask = 1'b1;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    m.start();
    repeat (8) @(negedge sys_clk);
    chk(bus_busy_flag === 1'b1 && !scl_o && !sda_o, "busy");
    wr({own_addr ^ 7'h01, 1'b0}, 1'b1);
    chk(ack === 1'b1 && irq_flag === 1'b0, "mismatch acked");
    wr(8'h00, 1'b1);
    chk(ack === 1'b1 && rx_buf_full === 1'b0, "frame taken");
    m.stop();
    repeat (8) @(negedge sys_clk);
    chk(!bus_busy_flag && stop_flag && !irq_flag, "masked stop");
    chk(!error_stop_flag, "no error stop");
    pulse(4);
    $display("test mismatch done");
    for (int h = 1; h >= 0; h--) begin
      handshake_hold_en = h[0];
      ext_addr_match_flag = h[0];
      stop_irq_mask = 1'b0;
      ack_data_wval = 1'b0;
      pulse(0);
      pulse(2);
      chk(rx_buf_full === 1'b0, "rx not empty");
      m.start();
      wr({own_addr, 1'b0}, 1'b1);
      chk(!ack && irq_flag && !tx_select, "write address");
      chk(irq_out === 1'b1, "irq out");
      pulse(6);
      pulse(2);
      pulse(3);
      for (int k = 0; k < 2; k++) begin
        seed = lfsr(seed);
        exp_q.push_back(seed[7:0]);
        if (k == 1) begin
          ack_data_wval = 1'b1;
          pulse(0);
        end
        wr(seed[7:0], 1'b1);
        chk(ack === ack_data_wval && rx_buf_full && irq_flag, "rx");
        if (h == 1) begin
          chk(scl_oe_n === 1'b0 && xfer_request_flag, "hold");
          chk(data_reg_rdata === exp_q.pop_front(), "rx data");
          pulse(6);
          pulse(2);
          pulse(3);
          chk(!rx_buf_full && scl_oe_n === 1'b1, "release");
        end
      end
      if (h == 0) begin
        chk(data_reg_rdata === exp_q.pop_front(), "first");
        chk(!xfer_request_flag, "no xfer request");
        pulse(2);
        pulse(6);
        chk(rx_buf_full && irq_flag, "pending moved");
        chk(data_reg_rdata === exp_q.pop_front(), "second");
        pulse(6);
      end
      pulse(2);
      m.stop();
      repeat (8) @(negedge sys_clk);
      chk(stop_flag && !bus_busy_flag && irq_flag, "stop");
      chk(!error_stop_flag, "clean stop");
      pulse(4);
      pulse(2);
      $display("test receive done");
    end
    m.start();
    wr({own_addr, 1'b1}, 1'b1);
    chk(!ack && tx_select && tx_buf_empty, "read address");
    chk(scl_oe_n === 1'b0, "tx stretch");
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      data_reg_wdata = seed[7:0];
      exp_q.push_back(seed[7:0]);
      pulse(5);
      pulse(2);
      chk(tx_buf_empty === 1'b1, "loaded");
      wr(8'hff, k[0]);
      chk(rb === exp_q.pop_front(), "tx data");
      chk(ack_data_bit === k[0], "tx ack");
      chk(irq_flag && scl_oe_n === 1'b0, "tx end");
    end
    ack_data_wval = 1'b0;
    pulse(0);
    pulse(1);
    pulse(6);
    m.stop();
    repeat (8) @(negedge sys_clk);
    chk(stop_flag && !bus_busy_flag, "tx stop");
    $display("test transmit done");
    pulse(4);
    m.start();
    wr({own_addr, 1'b0}, 1'b1);
    m.clk(1'b1, ack);
    m.clk(1'b0, ack);
    m.stop();
    repeat (8) @(negedge sys_clk);
    chk(error_stop_flag && !stop_flag && !bus_busy_flag, "cut");
    $display("test error stop done");
    results();
  end
endmodule : tb_top
